// file: shared/srst_pkg.sv
package srst_pkg;
  // command and pattern widths
  localparam int CMD_W = 8;
  localparam int MAGIC_W = 24;
  // software reset command byte
  localparam logic [7:0] SW_RESET_CMD = 8'hA1;
  // magic-sequence reset pattern
  localparam logic [23:0] MAGIC_PATTERN = 24'h06D926;
  // setup configuration field position and reset value
  localparam int CFG_LSB = 1;
  localparam int CFG_W = 3;
  localparam logic [2:0] CFG_RESET = 3'h0;
  // setup command code in the top three bits of a command byte
  localparam logic [2:0] SETUP_CODE = 3'h2;
  // control byte default
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // minimum reset period in ns and its length in mclk cycles
  localparam int RESET_PERIOD_NS = 200;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int RESET_CYCLES = (RESET_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // host sclk divider: half period in mclk cycles
  localparam int SCLK_HALF = 3;
endpackage : srst_pkg

// file: shared/srst_if.sv
`timescale 1ns/1ns
interface srst_if;
  logic sclk; // serial clock, made by the host
  logic cs_n; // chip select, active low
  logic mosi; // host to device data
  modport dev (input sclk, input cs_n, input mosi);
  modport host (output sclk, output cs_n, output mosi);
endinterface : srst_if

// file: src/srst_device.sv
`timescale 1ns/1ns
module srst_device (
  input wire logic mclk, // system clock
  input wire logic rst, // power-on reset, active high; synchronous in mclk, asynchronous on the link toggles and data
  srst_if.dev link, // serial pins
  output logic [srst_pkg::CFG_W-1:0] cfg, // setup configuration bits
  output logic [srst_pkg::CMD_W-1:0] ctrl, // last control byte
  output logic reset_busy // high while a reset is applied
);
  import srst_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // link domain: byte framing and magic detector on sclk
  logic [CMD_W-1:0] sh; // command shift register
  logic [2:0] bitc; // bit position within byte
  logic [MAGIC_W-1:0] msh; // magic shift register
  logic [CMD_W-1:0] byte_q; // captured byte
  logic byte_tg; // toggles per byte other than the software reset command
  logic sw_tg; // toggles per software reset
  logic mg_tg; // toggles per magic match
  logic [CMD_W-1:0] next_sh;
  logic [MAGIC_W-1:0] next_msh;
  logic [CMD_W-1:0] next_byte_q;
  logic [2:0] next_bitc;
  logic next_byte_tg, next_sw_tg, next_mg_tg;

  // next link state
  always_comb begin
    next_sh = {sh[CMD_W-2:0], link.mosi};
    next_msh = {msh[MAGIC_W-2:0], link.mosi};
    next_bitc = bitc + 3'h1;
    next_byte_q = byte_q;
    next_byte_tg = byte_tg;
    next_sw_tg = sw_tg;
    next_mg_tg = mg_tg;
    if (bitc == 3'h7) begin
      next_byte_q = next_sh;
      if (next_sh == SW_RESET_CMD) begin
        next_sw_tg = ~sw_tg;
      end else begin
        next_byte_tg = ~byte_tg;
      end
    end
    if (next_msh == MAGIC_PATTERN) begin
      next_mg_tg = ~mg_tg;
      next_msh = '0;
    end
  end

  // link registers; deselect clears framing and detector
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      sh <= '0;
      bitc <= 3'h0;
      msh <= '0;
    end else begin
      sh <= next_sh;
      bitc <= next_bitc;
      msh <= next_msh;
    end
  end

  // event toggles and data keep their value across frames
  // power-on reset clears them asynchronously, since sclk is stopped in reset;
  // without it the toggles would stay unknown and no event could ever cross
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      byte_q <= CTRL_RESET;
      byte_tg <= 1'b0;
      sw_tg <= 1'b0;
      mg_tg <= 1'b0;
    end else if (!link.cs_n) begin
      byte_q <= next_byte_q;
      byte_tg <= next_byte_tg;
      sw_tg <= next_sw_tg;
      mg_tg <= next_mg_tg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // crossing into mclk
  logic [2:0] s1, s2, s3; // byte, sw, magic toggles
  logic [2:0] next_s3;
  always_comb begin
    next_s3 = s2;
  end
  always_ff @(posedge mclk) begin
    s1 <= {byte_tg, sw_tg, mg_tg};
    s2 <= s1;
    s3 <= next_s3;
  end
  logic byte_ev, sw_ev, mg_ev;
  assign byte_ev = s2[2] ^ s3[2];
  assign sw_ev = s2[1] ^ s3[1];
  assign mg_ev = s2[0] ^ s3[0];

  ////////////////////////////////////////////////////////////////////
  // configuration state in mclk
  logic [7:0] rcnt; // reset period counter
  logic [CFG_W-1:0] next_cfg;
  logic [CMD_W-1:0] next_ctrl;
  logic [7:0] next_rcnt;

  // next configuration
  always_comb begin
    next_cfg = cfg;
    next_ctrl = ctrl;
    next_rcnt = (rcnt != 8'h00) ? rcnt - 8'h01 : 8'h00;
    if (mg_ev || sw_ev) begin
      next_cfg = CFG_RESET;
      next_ctrl = CTRL_RESET;
      next_rcnt = 8'(RESET_CYCLES);
    end else if (byte_ev && rcnt == 8'h00) begin
      next_ctrl = byte_q; // byte_q stable long before toggle arrives
      if (byte_q[7:5] == SETUP_CODE) begin
        next_cfg = byte_q[CFG_LSB +: CFG_W];
      end
    end
  end

  // registers; power-on reset defaults
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg <= CFG_RESET;
      ctrl <= CTRL_RESET;
      rcnt <= 8'h00;
    end else begin
      cfg <= next_cfg;
      ctrl <= next_ctrl;
      rcnt <= next_rcnt;
    end
  end

  assign reset_busy = rst || (rcnt != 8'h00);
endmodule : srst_device

// file: src/srst_host.sv
`timescale 1ns/1ns
module srst_host (
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic req_sw, // pulse: send software reset byte
  input wire logic req_magic, // pulse: send magic sequence
  output logic busy, // transfer in progress
  srst_if.host link // serial pins
);
  import srst_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // shift engine; sclk divided from mclk
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    SHIFT = 3'b010,
    LAG = 3'b100
  } srst_st_t;
  srst_st_t st, next_st;
  logic [MAGIC_W-1:0] data, next_data;
  logic [4:0] left, next_left; // bits remaining
  logic [1:0] div, next_div; // half-period counter
  logic sclk_q, next_sclk;
  logic cs_q, next_cs;

  // next values
  always_comb begin
    next_st = st;
    next_data = data;
    next_left = left;
    next_div = div;
    next_sclk = sclk_q;
    next_cs = cs_q;
    unique case (st)
      IDLE: begin
        if (req_magic) begin
          next_data = MAGIC_PATTERN;
          next_left = 5'(MAGIC_W);
          next_cs = 1'b0;
          next_div = 2'h0;
          next_st = SHIFT;
        end else if (req_sw) begin
          next_data = {SW_RESET_CMD, 16'h0000};
          next_left = 5'(CMD_W);
          next_cs = 1'b0;
          next_div = 2'h0;
          next_st = SHIFT;
        end
      end
      SHIFT: begin
        next_div = div + 2'h1;
        if (div == 2'(SCLK_HALF - 1)) begin
          next_div = 2'h0;
          next_sclk = ~sclk_q;
          if (sclk_q) begin
            next_data = {data[MAGIC_W-2:0], 1'b0};
            next_left = left - 5'h1;
            if (left == 5'h1) begin
              next_st = LAG;
            end
          end
        end
      end
      LAG: begin
        next_div = div + 2'h1;
        if (div == 2'(SCLK_HALF - 1)) begin
          next_cs = 1'b1;
          next_st = IDLE;
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= IDLE;
      data <= '0;
      left <= 5'h00;
      div <= 2'h0;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      st <= next_st;
      data <= next_data;
      left <= next_left;
      div <= next_div;
      sclk_q <= next_sclk;
      cs_q <= next_cs;
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_q;
  assign link.mosi = data[MAGIC_W-1];
  assign busy = (st != IDLE);
endmodule : srst_host

// file: dv/srst_monitor.sv
`timescale 1ns/1ns
// wire checks on the link joining host and device
module srst_monitor (
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic sclk, // serial clock
  input wire logic cs_n, // chip select, active low
  input wire logic mosi // serial data
);
  logic [4:0] nrise; // sclk rises in this frame
  logic [4:0] next_nrise; // next rise count
  logic sclk_q; // sclk one mclk ago
  logic next_sclk_q; // next delayed sclk
  // count rises while selected
  always_comb begin
    next_sclk_q = sclk;
    next_nrise = cs_n ? 5'h00 : nrise + 5'(sclk && !sclk_q);
  end
  always_ff @(posedge mclk) begin
    sclk_q <= next_sclk_q;
    nrise <= next_nrise;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("sclk moves while deselected");
  a_reset_deselects: assert property (disable iff (1'b0) rst |=> cs_n && !sclk)
    else $error("link not idle in reset");
  a_high_half: assert property ($rose(sclk) |-> sclk [*3] ##1 !sclk)
    else $error("sclk high phase wrong");
  a_low_half: assert property ($fell(sclk) |-> !sclk [*3])
    else $error("sclk low phase short");
  a_lead_low: assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
    else $error("sclk rises too soon");
  a_data_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_frame_bits: assert property ($rose(cs_n) |-> nrise == 5'h08 || nrise == 5'h18)
    else $error("frame length not 8 or 24");
  a_frame_ends: assert property ($fell(cs_n) |-> ##[1:250] cs_n)
    else $error("frame never closed");
endmodule : srst_monitor

// file: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import srst_pkg::*;
  logic mclk = 1'b0; // system clock
  logic rst = 1'b0; // reset, raised at time 0 so its edge is seen
  logic req_sw = 1'b0; // software reset request
  logic req_magic = 1'b0; // magic reset request
  logic busy; // host busy
  logic [2:0] cfg0, cfg1; // setup bits
  logic [7:0] ctrl0, ctrl1; // control bytes
  logic rb0, rb1; // reset busy
  int n_errors = 0; // mismatches
  int checked = 0; // comparisons
  int cyc = 0; // cycle count
  srst_if link0 ();
  srst_if link1 ();
  srst_host srst_host_inst (.mclk(mclk), .rst(rst), .req_sw(req_sw), .req_magic(req_magic),
    .busy(busy), .link(link0.host));
  srst_device srst_device_inst (.mclk(mclk), .rst(rst), .link(link0.dev), .cfg(cfg0),
    .ctrl(ctrl0), .reset_busy(rb0));
  srst_device srst_device_inst_b (.mclk(mclk), .rst(rst), .link(link1.dev), .cfg(cfg1),
    .ctrl(ctrl1), .reset_busy(rb1));
  srst_monitor srst_monitor_inst (.mclk(mclk), .rst(rst), .sclk(link0.sclk),
    .cs_n(link0.cs_n), .mosi(link0.mosi));
  initial begin
    link1.sclk <= 1'b0;
    link1.cs_n <= 1'b1;
    link1.mosi <= 1'b1;
  end
  always #5 mclk = ~mclk;
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one framed transfer on the second link, 48 ns sclk
  task tx(input logic [31:0] v, input int n);
    @(posedge mclk) link1.cs_n <= 1'b0;
    #7;
    for (int i = n - 1; i >= 0; i--) begin
      link1.mosi = v[i];
      #24 link1.sclk = 1'b1;
      #24 link1.sclk = 1'b0;
    end
    #20 link1.cs_n = 1'b1;
    link1.mosi = ~link1.mosi;
    repeat (10) @(posedge mclk);
  endtask : tx
  task t_sw;
    tx(32'h4E, 8);
    check(cfg1, 8'h07);
    tx(32'(SW_RESET_CMD), 8);
    check(rb1, 1'b1);
    check(cfg1, CFG_RESET);
    check(ctrl1, CTRL_RESET);
    repeat (RESET_CYCLES) @(posedge mclk);
    check(rb1, 1'b0);
  endtask : t_sw
  task t_magic;
    tx(32'h4E, 8);
    tx({5'h00, 3'h5, MAGIC_PATTERN}, 27);
    check(rb1, 1'b1);
    check(cfg1, CFG_RESET);
    check(ctrl1, CTRL_RESET);
    repeat (RESET_CYCLES) @(posedge mclk);
  endtask : t_magic
  task t_split;
    tx(32'h4E, 8);
    tx(32'h06D9, 16);
    tx(32'h26, 8);
    check(rb1, 1'b0);
    check(cfg1, 8'h07);
    check(ctrl1, 8'h26);
  endtask : t_split
  task t_host(input logic m);
    @(posedge mclk);
    req_magic <= m;
    req_sw <= !m;
    @(posedge mclk);
    req_magic <= 1'b0;
    req_sw <= 1'b0;
    #1;
    check(busy, 1'b1);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge mclk) #1;
    check(busy, 1'b0);
    check(rb0, 1'b1);
    repeat (RESET_CYCLES + 5) @(posedge mclk);
    check(rb0, 1'b0);
    check(cfg0, CFG_RESET);
  endtask : t_host
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 check(rb1, 1'b1);
    @(posedge mclk) rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check(cfg1, CFG_RESET);
    check(ctrl0, CTRL_RESET);
    t_sw();
    t_magic();
    t_split();
    t_host(1'b0);
    t_host(1'b1);
    finish_test();
  end
endmodule : tb_top
